//--- common/gpcn_map.vh
// Behaviour
// - enabled watched input changing state raises the change interrupt request
// - change detection works with the bus clock stopped during sleep
// - twenty-four watched inputs, each with its own enable
// - irq enables: inputs 0-15 in low register, 16-23 in high low byte
// - pull-up enables: same layout in two more registers, reset off
// - port d direction resets to all ones, every pin an input
// - port d latch and pin-level registers reset to zero
// - port f implements bits 8..0, direction resets to 0x01FF
// - port g implements 15..12, 9..6, 3..0, direction resets 0xF3CF
// - port f and g latch and pin-level registers reset to zero
// - direction one makes pin input; zero drives latch onto pin
`ifndef GPCN_MAP_VH
`define GPCN_MAP_VH
// offsets are word indices; the byte address on the bus is four times that
`define GPCN_OFS_CN_IE_LO  12'h0C0
`define GPCN_OFS_CN_IE_HI  12'h0C2
`define GPCN_OFS_CN_PU_LO  12'h0C4
`define GPCN_OFS_CN_PU_HI  12'h0C6
`define GPCN_OFS_CN_STAT   12'h0C8
`define GPCN_OFS_DIR_D     12'h2D2
`define GPCN_OFS_PIN_D     12'h2D4
`define GPCN_OFS_LAT_D     12'h2D6
`define GPCN_OFS_DIR_F     12'h2DE
`define GPCN_OFS_PIN_F     12'h2E0
`define GPCN_OFS_LAT_F     12'h2E2
`define GPCN_OFS_DIR_G     12'h2E4
`define GPCN_OFS_PIN_G     12'h2E6
`define GPCN_OFS_LAT_G     12'h2E8
`define GPCN_MASK_D        16'hFFFF
`define GPCN_MASK_F        16'h01FF
`define GPCN_MASK_G        16'hF3CF
`define GPCN_MASK_CN_HI    16'h00FF
`define GPCN_RST_DIR_D     16'hFFFF
`define GPCN_RST_DIR_F     16'h01FF
`define GPCN_RST_DIR_G     16'hF3CF
`define GPCN_RST_ZERO      16'h0000
`define GPCN_CN_NUM        24
`endif

//--- core/gpcn_cn_detect.v
`timescale 1ns/100ps
`include "gpcn_map.vh"
// the reference tracks the synchronised inputs; the raw compare is pure
// logic, so a pin change still requests a wake with clk stopped in sleep
module gpcn_cn_detect (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire [23:0] cn_in,
	input  wire [23:0] cn_en,
	input  wire        flag_clr,
	output wire        cn_wake,
	output reg         cn_flag_q
);
	wire [23:0] cn_sync;
	reg  [23:0] ref_q;
	wire [23:0] diff_raw;
	wire [23:0] diff_sync;
	gpcn_sync2 #(.W(24)) u_sync (
		.clk (clk),
		.d   (cn_in),
		.q   (cn_sync)
	);
	// raw compare against reference: needs no clock, used as wake request
	assign diff_raw  = (cn_in ^ ref_q) & cn_en;
	assign cn_wake   = |diff_raw;
	assign diff_sync = (cn_sync ^ ref_q) & cn_en;
	always @(posedge clk) begin
		if (sys_rst) begin
			ref_q     <= 24'h000000;
			cn_flag_q <= 1'b0;
		end else begin
			ref_q <= cn_sync;
			// a change in the clear cycle still sets the flag
			if (|diff_sync)
				cn_flag_q <= 1'b1;
			else if (flag_clr)
				cn_flag_q <= 1'b0;
		end
	end
endmodule

//--- core/gpcn_sync2.v
`timescale 1ns/100ps
module gpcn_sync2 #(
	parameter W = 16
) (
	input  wire         clk,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	// first stage feeds only the second stage
	always @(posedge clk) begin
		s1_q <= d;
		s2_q <= s1_q;
	end
	assign q = s2_q;
endmodule

//--- core/gpcn_top.v
`timescale 1ns/100ps
`include "gpcn_map.vh"
module gpcn_top (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire [15:0] pin_d_in,
	output wire [15:0] pin_d_out,
	output wire [15:0] pin_d_oe_n,
	input  wire [15:0] pin_f_in,
	output wire [15:0] pin_f_out,
	output wire [15:0] pin_f_oe_n,
	input  wire [15:0] pin_g_in,
	output wire [15:0] pin_g_out,
	output wire [15:0] pin_g_oe_n,
	input  wire [23:0] watched_input,
	output wire [23:0] watched_input_pullup_enable,
	output wire        cn_irq,
	output wire        cn_wake
);
	reg  [15:0] dir_d_q;
	reg  [15:0] dir_f_q;
	reg  [15:0] dir_g_q;
	reg  [15:0] lat_d_q;
	reg  [15:0] lat_f_q;
	reg  [15:0] lat_g_q;
	reg  [15:0] lvl_d_q;
	reg  [15:0] lvl_f_q;
	reg  [15:0] lvl_g_q;
	reg  [15:0] ie_lo_q;
	reg  [15:0] ie_hi_q;
	reg  [15:0] pu_lo_q;
	reg  [15:0] pu_hi_q;
	reg         wr_pend_q;
	reg  [11:0] wr_addr_q;
	wire [15:0] sd;
	wire [15:0] sf;
	wire [15:0] sg;
	wire        cn_flag;
	wire        cn_clr;
	wire        a_ok;
	wire [15:0] wd;
	reg  [31:0] rd_d;
	wire [11:0] rd_idx;
	wire [23:0] cn_en;
	wire        we_ie_lo;
	wire        we_ie_hi;
	wire        we_pu_lo;
	wire        we_pu_hi;
	wire        we_dir_d;
	wire        we_dir_f;
	wire        we_dir_g;
	wire        we_lat_d;
	wire        we_lat_f;
	wire        we_lat_g;
	wire        we_stat;
	reg  [15:0] oe_d_q;
	reg  [15:0] oe_f_q;
	reg  [15:0] oe_g_q;

	// pad value seen: latch when output, synchronised pin when input
	function [15:0] gpcn_pin_val;
		input [15:0] dir;
		input [15:0] lat;
		input [15:0] pin;
		input [15:0] mask;
		begin
			gpcn_pin_val = ((dir & pin) | (~dir & lat)) & mask;
		end
	endfunction

	// strobe for one register in the data phase of a write
	function gpcn_wsel;
		input        pend;
		input [11:0] idx;
		input [11:0] reg_idx;
		begin
			gpcn_wsel = pend & (idx == reg_idx);
		end
	endfunction

	// unimplemented bits are cut on the way in, so they read back zero
	function [15:0] gpcn_wmask;
		input [15:0] data;
		input [15:0] mask;
		begin
			gpcn_wmask = data & mask;
		end
	endfunction

	gpcn_sync2 #(.W(16)) u_sd (
		.clk (clk),
		.d   (pin_d_in),
		.q   (sd)
	);

	gpcn_sync2 #(.W(16)) u_sf (
		.clk (clk),
		.d   (pin_f_in),
		.q   (sf)
	);

	gpcn_sync2 #(.W(16)) u_sg (
		.clk (clk),
		.d   (pin_g_in),
		.q   (sg)
	);

	gpcn_cn_detect u_cn (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.cn_in     (watched_input),
		.cn_en     (cn_en),
		.flag_clr  (cn_clr),
		.cn_wake   (cn_wake),
		.cn_flag_q (cn_flag)
	);

	assign cn_irq = cn_flag;
	// enable bits past input 23 do not exist, so the high byte is dropped
	assign cn_en  = {ie_hi_q[7:0], ie_lo_q};
	assign watched_input_pullup_enable = {pu_hi_q[7:0], pu_lo_q};
	// oe_n low drives; direction one releases the pin
	assign pin_d_oe_n = oe_d_q;
	assign pin_f_oe_n = oe_f_q;
	assign pin_g_oe_n = oe_g_q;
	assign pin_d_out  = lat_d_q;
	assign pin_f_out  = lat_f_q;
	assign pin_g_out  = lat_g_q;

	// every register answers in its data phase, so no wait states
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign a_ok      = hsel & htrans[1] & hready;
	assign wd        = hwdata[15:0];
	assign rd_idx    = haddr[13:2];

	// one strobe per register; the pin-level word aliases the latch
	assign we_ie_lo = gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_CN_IE_LO);
	assign we_ie_hi = gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_CN_IE_HI);
	assign we_pu_lo = gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_CN_PU_LO);
	assign we_pu_hi = gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_CN_PU_HI);
	assign we_dir_d = gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_DIR_D);
	assign we_dir_f = gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_DIR_F);
	assign we_dir_g = gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_DIR_G);
	assign we_lat_d = gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_LAT_D)
		| gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_PIN_D);
	assign we_lat_f = gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_LAT_F)
		| gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_PIN_F);
	assign we_lat_g = gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_LAT_G)
		| gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_PIN_G);
	assign we_stat  = gpcn_wsel(wr_pend_q, wr_addr_q, `GPCN_OFS_CN_STAT);
	// writing one to status bit 0 clears the change flag
	assign cn_clr   = we_stat & hwdata[0];

	// pin levels sampled each cycle; the one-cycle lag is why software
	// must leave a gap between a port write and reading it back
	always @(posedge clk) begin
		if (sys_rst) begin
			lvl_d_q <= `GPCN_RST_ZERO;
		end else begin
			lvl_d_q <= gpcn_pin_val(dir_d_q, lat_d_q, sd, `GPCN_MASK_D);
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			lvl_f_q <= `GPCN_RST_ZERO;
		end else begin
			lvl_f_q <= gpcn_pin_val(dir_f_q, lat_f_q, sf, `GPCN_MASK_F);
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			lvl_g_q <= `GPCN_RST_ZERO;
		end else begin
			lvl_g_q <= gpcn_pin_val(dir_g_q, lat_g_q, sg, `GPCN_MASK_G);
		end
	end

	// pad enables come from flops, so decode glitches never reach a pad
	always @(posedge clk) begin
		if (sys_rst) begin
			oe_d_q <= `GPCN_RST_DIR_D | ~`GPCN_MASK_D;
		end else begin
			oe_d_q <= dir_d_q | ~`GPCN_MASK_D;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			oe_f_q <= `GPCN_RST_DIR_F | ~`GPCN_MASK_F;
		end else begin
			oe_f_q <= dir_f_q | ~`GPCN_MASK_F;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			oe_g_q <= `GPCN_RST_DIR_G | ~`GPCN_MASK_G;
		end else begin
			oe_g_q <= dir_g_q | ~`GPCN_MASK_G;
		end
	end

	// only the word index is kept; upper address bits alias
	always @(posedge clk) begin
		if (sys_rst) begin
			wr_pend_q <= 1'b0;
		end else begin
			wr_pend_q <= a_ok & hwrite;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			wr_addr_q <= 12'h000;
		end else begin
			wr_addr_q <= haddr[13:2];
		end
	end

	// data-phase writes, one register per process
	always @(posedge clk) begin
		if (sys_rst) begin
			ie_lo_q <= `GPCN_RST_ZERO;
		end else if (we_ie_lo) begin
			ie_lo_q <= wd;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			ie_hi_q <= `GPCN_RST_ZERO;
		end else if (we_ie_hi) begin
			ie_hi_q <= gpcn_wmask(wd, `GPCN_MASK_CN_HI);
		end
	end

	// pull-up enables are plain levels straight to the pads
	always @(posedge clk) begin
		if (sys_rst) begin
			pu_lo_q <= `GPCN_RST_ZERO;
		end else if (we_pu_lo) begin
			pu_lo_q <= wd;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			pu_hi_q <= `GPCN_RST_ZERO;
		end else if (we_pu_hi) begin
			pu_hi_q <= gpcn_wmask(wd, `GPCN_MASK_CN_HI);
		end
	end

	// direction and latch words mask off pins that do not exist
	always @(posedge clk) begin
		if (sys_rst) begin
			dir_d_q <= `GPCN_RST_DIR_D;
		end else if (we_dir_d) begin
			dir_d_q <= wd;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			dir_f_q <= `GPCN_RST_DIR_F;
		end else if (we_dir_f) begin
			dir_f_q <= gpcn_wmask(wd, `GPCN_MASK_F);
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			dir_g_q <= `GPCN_RST_DIR_G;
		end else if (we_dir_g) begin
			dir_g_q <= gpcn_wmask(wd, `GPCN_MASK_G);
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			lat_d_q <= `GPCN_RST_ZERO;
		end else if (we_lat_d) begin
			lat_d_q <= wd;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			lat_f_q <= `GPCN_RST_ZERO;
		end else if (we_lat_f) begin
			lat_f_q <= gpcn_wmask(wd, `GPCN_MASK_F);
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			lat_g_q <= `GPCN_RST_ZERO;
		end else if (we_lat_g) begin
			lat_g_q <= gpcn_wmask(wd, `GPCN_MASK_G);
		end
	end

	// read mux from the address phase; unmapped reads give zero
	always @* begin
		rd_d = 32'h00000000;
		case (rd_idx)
		`GPCN_OFS_CN_IE_LO: rd_d[15:0] = ie_lo_q;
		`GPCN_OFS_CN_IE_HI: rd_d[15:0] = ie_hi_q;
		`GPCN_OFS_CN_PU_LO: rd_d[15:0] = pu_lo_q;
		`GPCN_OFS_CN_PU_HI: rd_d[15:0] = pu_hi_q;
		`GPCN_OFS_CN_STAT:  rd_d[0]    = cn_flag;
		`GPCN_OFS_DIR_D:    rd_d[15:0] = dir_d_q;
		`GPCN_OFS_PIN_D:    rd_d[15:0] = lvl_d_q;
		`GPCN_OFS_LAT_D:    rd_d[15:0] = lat_d_q;
		`GPCN_OFS_DIR_F:    rd_d[15:0] = dir_f_q;
		`GPCN_OFS_PIN_F:    rd_d[15:0] = lvl_f_q;
		`GPCN_OFS_LAT_F:    rd_d[15:0] = lat_f_q;
		`GPCN_OFS_DIR_G:    rd_d[15:0] = dir_g_q;
		`GPCN_OFS_PIN_G:    rd_d[15:0] = lvl_g_q;
		`GPCN_OFS_LAT_G:    rd_d[15:0] = lat_g_q;
		default:            rd_d = 32'h00000000;
		endcase
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			hrdata <= 32'h00000000;
		end else if (a_ok & ~hwrite) begin
			hrdata <= rd_d;
		end
	end
endmodule

//--- tb/gpcn_pad_model.sv
`timescale 1ns/100ps
module gpcn_pad (
	input  wire [15:0] out,
	input  wire [15:0] oe_n,
	input  wire [15:0] ext,
	output wire [15:0] lvl
);
	// a driven pin shows the latch, a released one the outside level
	assign lvl = (oe_n & ext) | (~oe_n & out);
endmodule

//--- tb/gpcn_top_assertions.sv
`timescale 1ns/100ps
module gpcn_chk (
	input wire        clk,
	input wire        sys_rst,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] hrdata,
	input wire [15:0] pin_d_oe_n,
	input wire [15:0] pin_f_out,
	input wire [15:0] pin_f_oe_n,
	input wire [15:0] pin_g_out,
	input wire [15:0] pin_g_oe_n,
	input wire [23:0] watched_input_pullup_enable,
	input wire        cn_irq
);
	wire wr = hsel && htrans[1] && hwrite && hready;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_pu_wr;
		wr && haddr[13:2] == 12'h0C4 ##1 1'b1;
	endsequence
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready okay");
	chk_rd_upper: assert property (hrdata[31:16] == 16'h0000)
		else $error("read data upper half set");
	chk_f_unimpl: assert property (&pin_f_oe_n[15:9] && !pin_f_out[15:9])
		else $error("port f unimplemented pin driven");
	chk_g_unimpl: assert property ((pin_g_out & 16'h0C30) == 16'h0000
		&& (pin_g_oe_n & 16'h0C30) == 16'h0C30)
		else $error("port g unimplemented pin driven");
	chk_dir_reset: assert property ($fell(sys_rst) |-> (&pin_d_oe_n)
		&& (&pin_f_oe_n) && (&pin_g_oe_n))
		else $error("pins not inputs after reset");
	chk_pu_reset: assert property ($fell(sys_rst) |-> !cn_irq
		&& watched_input_pullup_enable == 24'h000000)
		else $error("pullups or flag set after reset");
	chk_pu_write: assert property (s_pu_wr |=>
		watched_input_pullup_enable[15:0] == $past(hwdata[15:0]))
		else $error("pullup write not applied");
	chk_flag_hold: assert property (cn_irq && !$past(wr) |=> cn_irq)
		else $error("change flag dropped without clear");
endmodule
bind gpcn_top gpcn_chk u_chk (.clk, .sys_rst, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pin_d_oe_n,
	.pin_f_out, .pin_f_oe_n, .pin_g_out, .pin_g_oe_n,
	.watched_input_pullup_enable, .cn_irq);

//--- tb/gpio_ports_change_notify_tb.sv
`timescale 1ns/100ps
module gpio_ports_change_notify_tb;
	reg         clk = 1'b0;
	reg         sys_rst = 1'b1;
	reg         hsel = 1'b0;
	reg         hwrite = 1'b0;
	reg  [1:0]  htrans = 2'h0;
	reg  [31:0] haddr = 32'h0;
	reg  [31:0] hwdata = 32'h0;
	reg  [15:0] ext = 16'h0000;
	reg  [23:0] cn = 24'h000000;
	reg  [15:0] q;
	wire        hready, hresp, irq, wake;
	wire [31:0] hrdata;
	wire [15:0] dout, doe, dl, fo, foe, fl, go, goe, gl;
	wire [23:0] pu;
	integer     err_count = 0;
	integer     tests_run = 0;
	reg  [11:0] pa [0:2] = '{12'h2D2, 12'h2DE, 12'h2E4};
	reg  [15:0] mk [0:2] = '{16'hFFFF, 16'h01FF, 16'hF3CF};
	gpcn_top uut (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp,
		.hrdata, .pin_d_in(dl), .pin_d_out(dout), .pin_d_oe_n(doe),
		.pin_f_in(fl), .pin_f_out(fo), .pin_f_oe_n(foe), .pin_g_in(gl),
		.pin_g_out(go), .pin_g_oe_n(goe), .watched_input(cn),
		.watched_input_pullup_enable(pu), .cn_irq(irq), .cn_wake(wake));
	gpcn_pad pd (.out(dout), .oe_n(doe), .ext(ext), .lvl(dl));
	gpcn_pad pf (.out(fo), .oe_n(foe), .ext(ext), .lvl(fl));
	gpcn_pad pg (.out(go), .oe_n(goe), .ext(ext), .lvl(gl));
	initial forever #25 clk = ~clk;
	task wrap_up;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task ck(input string n, input [31:0] s, input [31:0] e);
		tests_run = tests_run + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	task wt;
		integer i;
		i = 0;
		do begin
			@(posedge clk);
			i = i + 1;
		end while (hready !== 1'b1 && i < 20);
		if (i >= 20) begin
			err_count = err_count + 1;
			wrap_up;
		end
	endtask
	task bus(input [11:0] a, input w, input [15:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {18'h00000, a, 2'b00};
		hwrite <= w;
		wt;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0000, d};
		wt;
		q = hrdata[15:0];
	endtask
	task rc(input string n, input [11:0] a, input [15:0] e);
		bus(a, 1'b0, 16'h0000);
		ck(n, {16'h0000, q}, {16'h0000, e});
	endtask
	// flag waits end on an edge so the next request starts there
	task wirq;
		integer i;
		i = 0;
		while (irq !== 1'b1 && i < 8) begin
			@(posedge clk);
			#1;
			i = i + 1;
		end
		ck("cn_irq", {31'h0, irq}, 32'h1);
		@(posedge clk);
	endtask
	task t_reset;
		reg [11:0] k;
		for (k = 0; k < 3; k = k + 1) begin
			rc("dir", pa[k], mk[k]);
			rc("lvl", pa[k] + 12'h002, 16'h0000);
			rc("lat", pa[k] + 12'h004, 16'h0000);
		end
		for (k = 0; k < 4; k = k + 1)
			rc("cn_reg", 12'h0C0 + (k << 1), 16'h0000);
		rc("unmapped", 12'h100, 16'h0000);
		$display("test reset done");
	endtask
	task t_port;
		reg [11:0] k;
		for (k = 0; k < 3; k = k + 1) begin
			bus(pa[k], 1'b1, 16'h0000);
			bus(pa[k] + 12'h004, 1'b1, 16'hA5A5);
		end
		repeat (3) @(posedge clk);
		ck("d_out", {doe, dout}, 32'h0000A5A5);
		ck("f_out", {foe, fo}, 32'hFE0001A5);
		ck("g_out", {goe, go}, 32'h0C30A185);
		ext <= 16'h5A5A;
		for (k = 0; k < 3; k = k + 1) begin
			rc("drv", pa[k] + 12'h002, 16'hA5A5 & mk[k]);
			bus(pa[k], 1'b1, 16'hFFFF);
			rc("dir_wr", pa[k], mk[k]);
			repeat (4) @(posedge clk);
			rc("in", pa[k] + 12'h002, 16'h5A5A & mk[k]);
		end
		$display("test port done");
	endtask
	task t_cn;
		reg [11:0] k;
		for (k = 0; k < 4; k = k + 1) begin
			bus(12'h0C0 + (k << 1), 1'b1, 16'hFFFF);
			rc("cn_wr", 12'h0C0 + (k << 1),
				k[0] ? 16'h00FF : 16'hFFFF);
		end
		ck("pullup", {8'h00, pu}, 32'h00FFFFFF);
		bus(12'h0C0, 1'b1, 16'h0001);
		bus(12'h0C2, 1'b1, 16'h0080);
		bus(12'h0C8, 1'b1, 16'h0001);
		cn <= 24'h000002;
		repeat (6) @(posedge clk);
		ck("masked", {31'h0, irq}, 32'h0);
		cn <= 24'h000003;
		#1;
		ck("wake", {31'h0, wake}, 32'h1);
		wirq;
		repeat (4) @(posedge clk);
		rc("status", 12'h0C8, 16'h0001);
		bus(12'h0C8, 1'b1, 16'h0001);
		repeat (2) @(posedge clk);
		ck("cleared", {31'h0, irq}, 32'h0);
		cn <= 24'h800003;
		wirq;
		$display("test change notify done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset;
		t_port;
		t_cn;
		wrap_up;
	end
endmodule
